// [src/kpc_defs.vh]
// Summary of operation
// - Configuration bit 0 at 0 turns the serial bus timeout on, at 1 turns it off.
// - Configuration bits 2:1 show who started the sounder: 00 idle, 01 serial write, 10 key, 11 alert.
// - With configuration bit 3 at 0 an enabled alert interrupt waits for key-scan interrupt timing, at 1 it fires at once.
// - With configuration bit 4 at 1 a falling alert edge raises an interrupt; at 0 the alert never interrupts.
// - With configuration bit 5 at 1 each falling alert edge sends the alarm-sound byte to the sounder.
// - With configuration bit 6 at 1 every debounced or autorepeated key sends the key-click byte to the sounder, unless an alarm-sound byte goes in the same cycle.
// - With configuration bit 7 at 0 scanning, sounder timing and interrupts stop, but alert reads and port writes work.
// - With configuration bit 7 at 1 key scanning runs and queued sounder commands are executed.
// - A 0 written to ports bits 2 to 6 pulls that open-drain output low, a 1 releases it.
// - Ports bit 7 controls its open-drain output the same way.
// - Ports bit 1 is taken only while the key-scan interrupt field is 00000, otherwise the write is ignored.
// - Ports bit 0 reads the present alert input level and ignores writes.
`ifndef KPC_DEFS_VH
`define KPC_DEFS_VH

// register offsets
`define KPC_ADDR_CONFIG      8'h04
`define KPC_ADDR_PORTS       8'h05

// reset values
`define KPC_CONFIG_RESET     8'h01
`define KPC_PORTS_RESET      8'hFE

// configuration fields
`define KPC_CFG_TIMEOUT_OFF  0
`define KPC_CFG_SND_LO       1
`define KPC_CFG_SND_HI       2
`define KPC_CFG_ALERT_NOW    3
`define KPC_CFG_ALERT_INT    4
`define KPC_CFG_ALERT_SND    5
`define KPC_CFG_KEY_SND      6
`define KPC_CFG_RUN          7

// writable configuration bits (status bits 2:1 are read-only)
`define KPC_CFG_WR_MASK      8'hF9

// ports fields
`define KPC_PORT_ALERT       0
`define KPC_PORT_INT         1

// sounder source codes
`define KPC_SND_IDLE         2'h0
`define KPC_SND_SERIAL       2'h1
`define KPC_SND_KEY          2'h2
`define KPC_SND_ALERT        2'h3

`endif

// [src/kpc_config_ports.v]
`timescale 1ns/1ps
`default_nettype none
`include "kpc_defs.vh"

module kpc_config_ports
(
    input  wire       i_clock,
    input  wire       i_srst,
    input  wire       i_wr_stb,
    input  wire       i_rd_stb,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_alert,
    input  wire       i_key_event,
    input  wire       i_key_int_tick,
    input  wire [4:0] i_key_int_sel,
    input  wire       i_alert_int_clr,
    input  wire       i_serial_snd,
    input  wire       i_snd_done,
    input  wire [7:0] i_key_sound,
    input  wire [7:0] i_alarm_sound,
    output reg  [7:0] o_rdata,
    output reg        o_rvalid,
    output reg        o_timeout_en,
    output reg        o_run,
    output reg        o_alert_int,
    output reg  [7:0] o_snd_cmd,
    output reg        o_snd_valid,
    output reg  [7:1] o_port_out,
    output reg  [7:1] o_port_oe_n
);

    // full-width copy of the ports reset value so bits 7..1 can be picked out
    localparam [7:0] PORTS_RESET = `KPC_PORTS_RESET;

    reg  [7:0] config_reg;
    reg  [7:0] config_next;
    reg  [7:1] ports_reg;
    reg  [7:1] ports_next;
    reg  [1:0] snd_src_reg;
    reg  [1:0] snd_src_next;
    reg        alert_meta_reg;
    reg        alert_sync_reg;
    reg        alert_prev_reg;
    reg        alert_pend_reg;
    reg        alert_pend_next;
    reg        alert_int_next;
    reg  [7:0] snd_cmd_next;
    reg        snd_valid_next;
    reg  [7:0] rdata_next;

    wire       cfg_wr;
    wire       ports_wr;
    wire       alert_fall;
    wire       running;

    assign cfg_wr     = i_wr_stb && (i_addr == `KPC_ADDR_CONFIG);
    assign ports_wr   = i_wr_stb && (i_addr == `KPC_ADDR_PORTS);
    assign alert_fall = alert_prev_reg && !alert_sync_reg;
    assign running    = config_reg[`KPC_CFG_RUN];

    // alert pin synchroniser and edge history
    always @(posedge i_clock)
    begin
        if (i_srst)
        begin
            alert_meta_reg <= 1'b1;
            alert_sync_reg <= 1'b1;
            alert_prev_reg <= 1'b1;
        end
        else
        begin
            alert_meta_reg <= i_alert;
            alert_sync_reg <= alert_meta_reg;
            alert_prev_reg <= alert_sync_reg;
        end
    end

    // configuration register: writable control bits plus sounder status
    always @*
    begin
        config_next = config_reg;
        if (cfg_wr)
        begin
            config_next = (i_wdata & `KPC_CFG_WR_MASK) | (config_reg & ~`KPC_CFG_WR_MASK);
        end
        config_next[`KPC_CFG_SND_HI:`KPC_CFG_SND_LO] = snd_src_next;
    end

    // ports register: bits 7..2 always, bit 1 only with key-scan interrupt off
    always @*
    begin
        ports_next = ports_reg;
        if (ports_wr)
        begin
            ports_next[7:2] = i_wdata[7:2];
            if (i_key_int_sel == 5'h00)
            begin
                ports_next[`KPC_PORT_INT] = i_wdata[`KPC_PORT_INT];
            end
        end
    end

    // sounder forwarding: alert sound wins over key click in the same cycle
    always @*
    begin
        snd_cmd_next   = o_snd_cmd;
        snd_valid_next = 1'b0;
        if (alert_fall && config_reg[`KPC_CFG_ALERT_SND])
        begin
            snd_cmd_next   = i_alarm_sound;
            snd_valid_next = 1'b1;
        end
        else if (i_key_event && config_reg[`KPC_CFG_KEY_SND])
        begin
            snd_cmd_next   = i_key_sound;
            snd_valid_next = 1'b1;
        end
    end

    // sounder source tracking; a new start wins over a completion
    always @*
    begin
        snd_src_next = snd_src_reg;
        if (i_snd_done)
        begin
            snd_src_next = `KPC_SND_IDLE;
        end
        if (alert_fall && config_reg[`KPC_CFG_ALERT_SND])
        begin
            snd_src_next = `KPC_SND_ALERT;
        end
        else if (i_key_event && config_reg[`KPC_CFG_KEY_SND])
        begin
            snd_src_next = `KPC_SND_KEY;
        end
        else if (i_serial_snd)
        begin
            snd_src_next = `KPC_SND_SERIAL;
        end
    end

    // alert interrupt: pend on edge, release now or at the key-scan tick
    always @*
    begin
        alert_pend_next = alert_pend_reg;
        alert_int_next  = o_alert_int;
        if (i_alert_int_clr)
        begin
            alert_int_next = 1'b0;
        end
        if (alert_fall && config_reg[`KPC_CFG_ALERT_INT] && running)
        begin
            alert_pend_next = 1'b1;
        end
        if (alert_pend_next && (config_reg[`KPC_CFG_ALERT_NOW] || i_key_int_tick))
        begin
            alert_int_next  = 1'b1;
            alert_pend_next = 1'b0;
        end
        if (!running)
        begin
            alert_int_next  = 1'b0;
            alert_pend_next = 1'b0;
        end
    end

    // read data mux; unmapped addresses read as zero
    always @*
    begin
        if (i_addr == `KPC_ADDR_CONFIG)
        begin
            rdata_next = config_reg;
        end
        else if (i_addr == `KPC_ADDR_PORTS)
        begin
            rdata_next = {ports_reg, alert_sync_reg};
        end
        else
        begin
            rdata_next = 8'h00;
        end
    end

    // state registers
    always @(posedge i_clock)
    begin
        if (i_srst)
        begin
            config_reg     <= `KPC_CONFIG_RESET;
            ports_reg      <= PORTS_RESET[7:1];
            snd_src_reg    <= `KPC_SND_IDLE;
            alert_pend_reg <= 1'b0;
        end
        else
        begin
            config_reg     <= config_next;
            ports_reg      <= ports_next;
            snd_src_reg    <= snd_src_next;
            alert_pend_reg <= alert_pend_next;
        end
    end

    // registered outputs
    always @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_rdata      <= 8'h00;
            o_rvalid     <= 1'b0;
            o_timeout_en <= 1'b0;
            o_run        <= 1'b0;
            o_alert_int  <= 1'b0;
            o_snd_cmd    <= 8'h00;
            o_snd_valid  <= 1'b0;
            o_port_out   <= 7'h00;
            o_port_oe_n  <= 7'h7F;
        end
        else
        begin
            o_rdata      <= i_rd_stb ? rdata_next : o_rdata;
            o_rvalid     <= i_rd_stb;
            o_timeout_en <= ~config_next[`KPC_CFG_TIMEOUT_OFF];
            o_run        <= config_next[`KPC_CFG_RUN];
            o_alert_int  <= alert_int_next;
            o_snd_cmd    <= snd_cmd_next;
            o_snd_valid  <= snd_valid_next;
            o_port_out   <= 7'h00; // open drain only ever pulls low
            o_port_oe_n  <= ports_next;
        end
    end

endmodule
`default_nettype wire

// [verif/kpc_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module kpc_checker (
    input wire logic       i_clock,
    input wire logic       i_srst,
    input wire logic       i_wr_stb,
    input wire logic       i_rd_stb,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [4:0] i_key_int_sel,
    input wire logic [7:0] o_rdata,
    input wire logic       o_timeout_en,
    input wire logic       o_run,
    input wire logic       o_alert_int,
    input wire logic [7:1] o_port_out,
    input wire logic [7:1] o_port_oe_n
);
    logic [7:0] cfg_reg;
    wire        cw = i_wr_stb && i_addr == 8'h04;
    wire        pw = i_wr_stb && i_addr == 8'h05;
    // shadow of the last configuration write
    always_ff @(posedge i_clock)
        cfg_reg <= i_srst ? 8'h01 : (cw ? i_wdata : cfg_reg);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    a_timeout_follows: assert property (cw |=> o_timeout_en == !$past(i_wdata[0]))
        else $error("timeout enable wrong");
    a_run_follows: assert property (cw |=> o_run == $past(i_wdata[7]))
        else $error("run mode wrong");
    a_ports_drive: assert property (pw |=> o_port_oe_n[6:2] == $past(i_wdata[6:2]))
        else $error("port enable wrong");
    a_port7_drive: assert property (pw |=> o_port_oe_n[7] == $past(i_wdata[7]))
        else $error("port 7 enable wrong");
    a_int_port_hold: assert property (pw && i_key_int_sel != 5'h00 |=> $stable(o_port_oe_n[1]))
        else $error("int port changed");
    a_open_drain_low: assert property (o_port_out == 7'h00)
        else $error("port output not low");
    a_shutdown_quiet: assert property (!o_run |=> !o_alert_int)
        else $error("interrupt in shutdown");
    a_config_readback: assert property (i_rd_stb && i_addr == 8'h04 |=>
        (o_rdata & 8'hF9) == ($past(cfg_reg) & 8'hF9))
        else $error("config readback wrong");
    c_alert_int: cover property (o_alert_int);
    c_int_port_held: cover property (pw && i_key_int_sel != 5'h00);
    c_run_write: cover property (cw && i_wdata[7]);
endmodule
bind kpc_config_ports kpc_checker kpc_checker_i (.*);
`default_nettype wire

// [verif/kpc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module kpc_host_model (
    input  wire logic       i_clock,
    output var  logic       o_wr_stb = 0,
    output var  logic       o_rd_stb = 0,
    output var  logic [7:0] o_addr = 0,
    output var  logic [7:0] o_wdata = 0,
    input  wire logic [7:0] i_rdata
);
    // one byte per call: held through the taking edge, then address and data scrambled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    begin
        @(posedge i_clock) #1;
        {o_wr_stb, o_rd_stb, o_addr, o_wdata} = {w, !w, a, d};
        @(posedge i_clock) #1;
        q = i_rdata;
        {o_wr_stb, o_rd_stb, o_addr, o_wdata} = {2'b00, ~a, ~d};
    end
    endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       i_clock = 0, i_srst = 1, i_alert = 1, i_key_event = 0, i_key_int_tick = 0;
    logic       i_alert_int_clr = 0, i_serial_snd = 0, i_snd_done = 0;
    logic [4:0] i_key_int_sel = 0;
    logic [7:0] i_key_sound = 0, i_alarm_sound = 0, d, q;
    logic [7:1] p = 7'h7F;
    logic [7:0] acfg [4] = '{8'hB8, 8'hB0, 8'hA8, 8'h38};
    wire        i_wr_stb, i_rd_stb, o_rvalid, o_timeout_en, o_run, o_alert_int, o_snd_valid;
    wire  [7:0] i_addr, i_wdata, o_rdata, o_snd_cmd;
    wire  [7:1] o_port_out, o_port_oe_n;
    int         errors = 0, comparisons = 0, cyc = 0;
    kpc_config_ports kpc_config_ports_i (.*);
    kpc_host_model kpc_host_model_i (.i_clock(i_clock), .o_wr_stb(i_wr_stb), .o_rd_stb(i_rd_stb),
        .o_addr(i_addr), .o_wdata(i_wdata), .i_rdata(o_rdata));
    // clock and hang guard
    always #12.5 i_clock = !i_clock;
    always @(posedge i_clock)
        if (++cyc == 3000)
        begin
            errors++;
            tally_and_finish();
        end
    // compare seen against expected
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
    begin
        comparisons++;
        if (s !== e)
        begin
            errors++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
        end
    end
    endtask
    task automatic tally_and_finish;
    begin
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    // bus access, one-cycle pulse, alert drop with bounded wait for its sound
    task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] v);
        kpc_host_model_i.xfer(w, a, v, q);
        chk(o_rvalid, !w);
    endtask
    task automatic pulse(ref logic s);
    begin
        s = 1;
        @(posedge i_clock) #1 s = 0;
    end
    endtask
    task automatic fall;
    begin
        i_alert = 0;
        for (int n = 0; n < 8 && o_snd_valid !== 1'b1; n++)
            @(posedge i_clock) #1;
    end
    endtask
    function automatic logic [7:0] cfg_exp(input logic [7:0] v, input logic [1:0] s);
        return (v & 8'hF9) | {5'h00, s, 1'b0};
    endfunction
    // main sequence
    initial
    begin
        void'($urandom(10));
        repeat (3) @(posedge i_clock);
        #1 i_srst = 0;
        rw(0, 8'h04, 0);
        chk(q, 8'h01);
        chk(o_timeout_en, 0);
        repeat (4)
        begin
            d = $urandom;
            rw(1, 8'h04, d);
            chk(o_timeout_en, !d[0]);
            chk(o_run, d[7]);
            rw(0, 8'h04, 0);
            chk(q, cfg_exp(d, 2'h0));
        end
        repeat (6)
        begin
            d = $urandom;
            i_key_int_sel = 5'($urandom) & 5'h03;
            p = {d[7:2], i_key_int_sel == 0 ? d[1] : p[1]};
            rw(1, 8'h05, d);
            chk(o_port_oe_n, p);
            rw(0, 8'h05, 0);
            chk(q, {p, 1'b1});
        end
        rw(0, 8'h3C, 0);
        chk(q, 8'h00);
        rw(1, 8'h04, 8'hC0);
        i_key_sound = $urandom;
        pulse(i_key_event);
        chk({o_snd_valid, o_snd_cmd}, {1'b1, i_key_sound});
        rw(0, 8'h04, 0);
        chk(q, cfg_exp(8'hC0, 2'h2));
        pulse(i_snd_done);
        pulse(i_serial_snd);
        rw(0, 8'h04, 0);
        chk(q, cfg_exp(8'hC0, 2'h1));
        pulse(i_snd_done);
        foreach (acfg[k])
        begin
            rw(1, 8'h04, acfg[k]);
            i_alarm_sound = $urandom;
            fall();
            chk({o_snd_valid, o_snd_cmd}, {1'b1, i_alarm_sound});
            chk(o_alert_int, acfg[k][7] & acfg[k][4] & acfg[k][3]);
            pulse(i_key_int_tick);
            rw(0, 8'h05, 0);
            chk(q[0], 0);
            chk(o_alert_int, acfg[k][7] & acfg[k][4]);
            i_alert = 1;
            pulse(i_alert_int_clr);
            chk(o_alert_int, 0);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
